// ---- design/led_defines.svh ----
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_LED_CTRL      8'h00
`define ADDR_RED_BLINK     8'h01
`define ADDR_RED_CYCLE     8'h02
`define ADDR_GREEN_BLINK   8'h03
`define ADDR_GREEN_CYCLE   8'h04
`define ADDR_BLUE_BLINK    8'h05
`define ADDR_BLUE_CYCLE    8'h06
`define ADDR_ENABLES       8'h0B
`define ADDR_SOFT_RESET    8'h60

// ************************************************************
// field positions
// ************************************************************
`define GRP1_TYPE_BIT      7
`define GRP2_TYPE_BIT      6
`define ON_MSB             7
`define ON_LSB             4
`define OFF_MSB            3
`define OFF_LSB            0
`define CYC_EN_BIT         3
`define CYC_CODE_MSB       2
`define CYC_CODE_LSB       0
`define SEL_MSB            1
`define SEL_LSB            0
`define SEL_BLINK          2'h1

// ************************************************************
// reset values and write masks
// ************************************************************
`define LED_CTRL_RST       8'hC0
`define BLINK_RST          8'h00
`define CYCLE_RST          4'h0
`define ENABLES_RST        8'h04
`define ENABLES_WMASK      8'h67

// ************************************************************
// timing
// ************************************************************
`define CLK_FREQ_KHZ       25000
`define TICK_TIME_MS       1
`define TICK_CYCLES        (`TICK_TIME_MS * `CLK_FREQ_KHZ)
`define POS_W              13

`endif

// ---- design/led_pkg.sv ----
package led_pkg;

    typedef struct packed {
        logic [7:0]      led_ctrl;
        logic [2:0][7:0] blink_times;
        logic [2:0][3:0] cycle_ctrl;
        logic [7:0]      enables;
        logic [7:0]      rdata;
        logic [5:0]      led_out;
        logic            soft_reset;
    } regs_s;

    typedef struct packed {
        logic [12:0] pos_ms;
        logic        out;
    } chan_s;

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } tick_s;

endpackage

// ---- design/blink_cfg_if.sv ----
interface blink_cfg_if;
    logic [3:0] on_code;
    logic [3:0] off_code;
    logic [2:0] cycle_code;
    logic       active;
    logic       blink_out;

    modport ctrl
    (
        output on_code,
        output off_code,
        output cycle_code,
        output active,
        input  blink_out
    );

    modport chan
    (
        input  on_code,
        input  off_code,
        input  cycle_code,
        input  active,
        output blink_out
    );
endinterface

// ---- design/blink_tick.sv ----
`include "led_defines.svh"

module blink_tick
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      tick
);
    led_pkg::tick_s st_reg;
    led_pkg::tick_s st_next;

    // ************************************************************
    // millisecond prescaler
    // ************************************************************
    always_comb
    begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.count == 32'(TICK_CYCLES - 1))
        begin
            st_next.count = 32'h0;
            st_next.tick  = 1'b1;
        end
        else
        begin
            st_next.count = st_reg.count + 32'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick = st_reg.tick;
endmodule // blink_tick

// ---- design/blink_channel.sv ----
module blink_channel
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       tick,
    blink_cfg_if.chan       cfg
);
    led_pkg::chan_s st_reg;
    led_pkg::chan_s st_next;

    // ************************************************************
    // code tables
    // ************************************************************
    function automatic int period_ms(input logic [2:0] code);
        case (code)
            3'h0:    period_ms = 100;
            3'h1:    period_ms = 250;
            3'h2:    period_ms = 500;
            3'h3:    period_ms = 1000;
            3'h4:    period_ms = 2000;
            3'h5:    period_ms = 3000;
            3'h6:    period_ms = 4000;
            default: period_ms = 5000;
        endcase
    endfunction

    function automatic int share_permille(input logic [3:0] code);
        case (code)
            4'h0:    share_permille = 0;
            4'h1:    share_permille = 10;
            4'h2:    share_permille = 25;
            4'h3:    share_permille = 50;
            4'h4:    share_permille = 75;
            4'h5:    share_permille = 100;
            4'h6:    share_permille = 150;
            4'h7:    share_permille = 200;
            4'hF:    share_permille = 1000;
            default: share_permille = (int'(code) - 5) * 100;
        endcase
    endfunction

    logic [12:0] on_ms;
    logic [12:0] off_ms;
    logic [13:0] total_ms;

    assign on_ms    = 13'((period_ms(cfg.cycle_code) * share_permille(cfg.on_code)) / 1000);
    assign off_ms   = 13'((period_ms(cfg.cycle_code) * share_permille(cfg.off_code)) / 1000);
    assign total_ms = {1'b0, on_ms} + {1'b0, off_ms};

    // ************************************************************
    // on phase then off phase, repeated
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        if (!cfg.active || total_ms == 14'h0)
        begin
            st_next.pos_ms = 13'h0;
            st_next.out    = 1'b0;
        end
        else if (tick)
        begin
            if ({1'b0, st_reg.pos_ms} >= total_ms - 14'h1)
                st_next.pos_ms = 13'h0;
            else
                st_next.pos_ms = st_reg.pos_ms + 13'h1;
            st_next.out = (st_next.pos_ms < on_ms);
        end
        else
        begin
            st_next.out = (st_reg.pos_ms < on_ms);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign cfg.blink_out = st_reg.out;
endmodule // blink_channel

// ---- design/led_output_control_blink_regs.sv ----
`include "led_defines.svh"

module led_output_control_blink_regs
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            red_output_one,
    output logic            green_output_one,
    output logic            blue_output_one,
    output logic            red_output_two,
    output logic            green_output_two,
    output logic            blue_output_two,
    output logic            group_one_drive_type,
    output logic            group_two_drive_type
);
    led_pkg::regs_s st_reg;
    led_pkg::regs_s st_next;
    led_pkg::regs_s st_rst;

    logic       dev_rst_b;
    logic       tick;
    logic [2:0] blink_out;
    logic       blink_sel;

    // ************************************************************
    // device reset, power-on or soft
    // ************************************************************
    assign dev_rst_b = rst_b & ~st_reg.soft_reset;

    always_comb
    begin
        st_rst             = '0;
        st_rst.led_ctrl    = `LED_CTRL_RST;
        st_rst.blink_times = {3{`BLINK_RST}};
        st_rst.cycle_ctrl  = {3{`CYCLE_RST}};
        st_rst.enables     = `ENABLES_RST;
    end

    // ************************************************************
    // blink engines for group one
    // ************************************************************
    blink_tick
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_tick
    (
        .clk   (clk),
        .rst_b (dev_rst_b),
        .tick  (tick)
    );

    assign blink_sel = (st_reg.enables[`SEL_MSB:`SEL_LSB] == `SEL_BLINK);

    blink_cfg_if cfg [3] ();

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_chan
            assign cfg[gi].on_code    = st_reg.blink_times[gi][`ON_MSB:`ON_LSB];
            assign cfg[gi].off_code   = st_reg.blink_times[gi][`OFF_MSB:`OFF_LSB];
            assign cfg[gi].cycle_code = st_reg.cycle_ctrl[gi][`CYC_CODE_MSB:`CYC_CODE_LSB];
            assign cfg[gi].active     = blink_sel & st_reg.cycle_ctrl[gi][`CYC_EN_BIT];
            assign blink_out[gi]      = cfg[gi].blink_out;

            blink_channel u_chan
            (
                .clk   (clk),
                .rst_b (dev_rst_b),
                .tick  (tick),
                .cfg   (cfg[gi].chan)
            );
        end
    endgenerate

    // ************************************************************
    // register access and output state
    // ************************************************************
    always_comb
    begin
        st_next            = st_reg;
        st_next.soft_reset = 1'b0;
        st_next.rdata      = 8'h00;

        if (reg_wr)
        begin
            case (reg_addr)
                `ADDR_LED_CTRL:    st_next.led_ctrl       = reg_wdata;
                `ADDR_RED_BLINK:   st_next.blink_times[0] = reg_wdata;
                `ADDR_GREEN_BLINK: st_next.blink_times[1] = reg_wdata;
                `ADDR_BLUE_BLINK:  st_next.blink_times[2] = reg_wdata;
                `ADDR_RED_CYCLE:   st_next.cycle_ctrl[0]  = reg_wdata[3:0];
                `ADDR_GREEN_CYCLE: st_next.cycle_ctrl[1]  = reg_wdata[3:0];
                `ADDR_BLUE_CYCLE:  st_next.cycle_ctrl[2]  = reg_wdata[3:0];
                `ADDR_ENABLES:     st_next.enables        = reg_wdata & `ENABLES_WMASK;
                `ADDR_SOFT_RESET:  st_next.soft_reset     = 1'b1;
                default:           st_next.soft_reset     = 1'b0;
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_LED_CTRL:    st_next.rdata = st_reg.led_ctrl;
                `ADDR_RED_BLINK:   st_next.rdata = st_reg.blink_times[0];
                `ADDR_GREEN_BLINK: st_next.rdata = st_reg.blink_times[1];
                `ADDR_BLUE_BLINK:  st_next.rdata = st_reg.blink_times[2];
                `ADDR_RED_CYCLE:   st_next.rdata = {4'h0, st_reg.cycle_ctrl[0]};
                `ADDR_GREEN_CYCLE: st_next.rdata = {4'h0, st_reg.cycle_ctrl[1]};
                `ADDR_BLUE_CYCLE:  st_next.rdata = {4'h0, st_reg.cycle_ctrl[2]};
                `ADDR_ENABLES:     st_next.rdata = st_reg.enables;
                default:           st_next.rdata = 8'h00;
            endcase
        end

        // group one: enable gates blink or steady on
        for (int i = 0; i < 3; i++)
        begin
            st_next.led_out[5 - i] = st_reg.led_ctrl[5 - i]
                                   & (cfg_active(i) ? blink_out[i] : 1'b1);
        end
        // group two: enable bits only
        st_next.led_out[2:0] = st_reg.led_ctrl[2:0];
    end

    function automatic logic cfg_active(input int idx);
        cfg_active = blink_sel & st_reg.cycle_ctrl[idx][`CYC_EN_BIT];
    endfunction

    always_ff @(posedge clk)
    begin
        if (!dev_rst_b)
            st_reg <= st_rst;
        else
            st_reg <= st_next;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata            = st_reg.rdata;
    assign red_output_one       = st_reg.led_out[5];
    assign green_output_one     = st_reg.led_out[4];
    assign blue_output_one      = st_reg.led_out[3];
    assign red_output_two       = st_reg.led_out[2];
    assign green_output_two     = st_reg.led_out[1];
    assign blue_output_two      = st_reg.led_out[0];
    assign group_one_drive_type = st_reg.led_ctrl[`GRP1_TYPE_BIT];
    assign group_two_drive_type = st_reg.led_ctrl[`GRP2_TYPE_BIT];
endmodule // led_output_control_blink_regs

// ---- sim/led_regs_chk.sv ----
module led_regs_chk
#(
    parameter int TICK_CYCLES = 25000
)
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       red_output_one,
    input wire logic       green_output_one,
    input wire logic       blue_output_one,
    input wire logic       red_output_two,
    input wire logic       green_output_two,
    input wire logic       blue_output_two,
    input wire logic       group_one_drive_type,
    input wire logic       group_two_drive_type
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [7:0] pins = {group_one_drive_type, group_two_drive_type, red_output_one,
        green_output_one, blue_output_one, red_output_two, green_output_two, blue_output_two};
    wire       ctl_wr = reg_wr && reg_addr == 8'h00;
    wire       sr_wr = reg_wr && reg_addr == 8'h60;
    wire       unmapped_rd = reg_rd && (reg_addr == 8'h60 || reg_addr == 8'h07);
    // ****
    // assertions
    // ****
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero");
    a_unmapped_read: assert property (unmapped_rd |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_state: assert property ($rose(rst_b) |-> pins == 8'hC0)
        else $error("reset pins wrong");
    a_type_one: assert property (ctl_wr && !$past(sr_wr)
        |-> ##1 pins[7] == $past(reg_wdata[7]))
        else $error("group one type wrong");
    a_type_two: assert property (ctl_wr && !$past(sr_wr)
        |-> ##1 pins[6] == $past(reg_wdata[6]))
        else $error("group two type wrong");
    a_group_two_en: assert property (ctl_wr && !$past(sr_wr)
        |-> ##2 pins[2:0] == $past(reg_wdata[2:0], 2))
        else $error("group two enables wrong");
    a_group_one_gate: assert property (ctl_wr && !$past(sr_wr)
        |-> ##2 (pins[5:3] & ~$past(reg_wdata[5:3], 2)) == 3'h0)
        else $error("disabled output on");
    a_soft_reset: assert property (sr_wr |-> ##2 pins == 8'hC0)
        else $error("soft reset missed");
endmodule // led_regs_chk

bind led_output_control_blink_regs led_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk
(
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .red_output_one(red_output_one), .green_output_one(green_output_one),
    .blue_output_one(blue_output_one), .red_output_two(red_output_two),
    .green_output_two(green_output_two), .blue_output_two(blue_output_two),
    .group_one_drive_type(group_one_drive_type), .group_two_drive_type(group_two_drive_type)
);

// ---- sim/led_host.sv ----
module led_host
(
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // ****
    // bus cycles, idle address shows inverse, wr also inverts data
    // ****
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule // led_host

// ---- sim/tb_led_output_control_blink_regs.sv ----
module tb_led_output_control_blink_regs;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 2;
    logic       clk;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] pins;
    int         mismatches;
    int         n_compared;
    int         pm [16] = '{0, 10, 25, 50, 75, 100, 150, 200, 300, 400, 500, 600, 700, 800,
                            900, 1000};
    int         per [8] = '{100, 250, 500, 1000, 2000, 3000, 4000, 5000};
    led_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    led_output_control_blink_regs #(.TICK_CYCLES(TK)) DUT
    (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .red_output_one(pins[5]), .green_output_one(pins[4]), .blue_output_one(pins[3]),
        .red_output_two(pins[2]), .green_output_two(pins[1]), .blue_output_two(pins[0]),
        .group_one_drive_type(pins[7]), .group_two_drive_type(pins[6])
    );
    // ****
    // checks
    // ****
    task results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        cmp({24'h0, d}, {24'h0, e});
    endtask
    task chk_pins(input logic [7:0] e);
        repeat (2) @(posedge clk);
        cmp({24'h0, pins}, {24'h0, e});
    endtask
    task chk_on(input int n, input int e, input int b);
        int c;
        c = 0;
        repeat (n) @(posedge clk) c += (pins[b] === 1'b1);
        cmp(c, e);
    endtask
    task blink(input logic [3:0] on, input logic [3:0] off, input logic [2:0] cy, input int np);
        int on_ms;
        int off_ms;
        host.wr(8'h02, 8'h00);
        host.wr(8'h01, {on, off});
        host.wr(8'h02, {5'h01, cy});
        on_ms = per[cy] * pm[on] / 1000;
        off_ms = per[cy] * pm[off] / 1000;
        repeat (4) @(posedge clk);
        chk_on(np * (on_ms + off_ms) * TK, np * on_ms * TK, 5);
    endtask
    // ****
    // stimulus
    // ****
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        results;
    end
    initial
    begin
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk_pins(8'hC0);
        chk_reg(8'h00, 8'hC0);
        chk_reg(8'h01, 8'h00);
        chk_reg(8'h03, 8'h00);
        chk_reg(8'h05, 8'h00);
        chk_reg(8'h60, 8'h00);
        chk_reg(8'h07, 8'h00);
        host.wr(8'h00, 8'h3F);
        chk_reg(8'h00, 8'h3F);
        chk_pins(8'h3F);
        host.wr(8'h00, 8'h95);
        chk_pins(8'h95);
        host.wr(8'h01, 8'h5A);
        host.wr(8'h03, 8'hA5);
        host.wr(8'h05, 8'hFF);
        chk_reg(8'h01, 8'h5A);
        chk_reg(8'h03, 8'hA5);
        chk_reg(8'h05, 8'hFF);
        host.wr(8'h60, 8'h5A);
        chk_reg(8'h00, 8'hC0);
        chk_reg(8'h03, 8'h00);
        chk_pins(8'hC0);
        host.wr(8'h0B, 8'hFF);
        chk_reg(8'h0B, 8'h67);
        host.wr(8'h0B, 8'h01);
        host.wr(8'h00, 8'hE0);
        for (int c = 0; c < 16; c++)
            blink(c[3:0], 4'hF - c[3:0], 3'h0, 2);
        for (int y = 0; y < 8; y++)
            blink(4'hA, 4'hA, y[2:0], 1);
        host.wr(8'h02, 8'h08);
        for (int s = 0; s < 4; s++)
        begin
            host.wr(8'h0B, {6'h00, s[1:0] ^ 2'h1});
            chk_on(400, s == 0 ? 200 : 400, 5);
        end
        host.wr(8'h0B, 8'h01);
        host.wr(8'h02, 8'h00);
        chk_on(400, 400, 5);
        host.wr(8'h00, 8'hF8);
        for (int g = 1; g < 3; g++)
        begin
            host.wr(8'(2 * g + 1), 8'hA5);
            host.wr(8'(2 * g + 2), 8'h08);
            repeat (4) @(posedge clk);
            chk_on(240, 200, 5 - g);
        end
        results;
    end
endmodule // tb_led_output_control_blink_regs
